// ==== logic/cdb_pkg.sv ====
package cdb_pkg;
	// ----------------------------------------------------------------
	// Bus shape
	// ----------------------------------------------------------------
	localparam int ADDR_W  = 32;
	localparam int DATA_W  = 32;
	localparam int LANES   = DATA_W / 8;
	localparam int MTYPE_W = 2;
	localparam int PROT_W  = 3;
	localparam int ACHK_W  = 8;
	// Memory type field positions
	localparam int MTYPE_BUF_BIT   = 0;
	localparam int MTYPE_CACHE_BIT = 1;
	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [ACHK_W-1:0] ACHK_RST = 8'h00;
	// Subordinate answers after this many cycles from the grant
	localparam int RESP_LAT = 1;

	typedef enum logic [1:0]
	{
		CDB_IDLE = 2'b00,
		CDB_REQ  = 2'b01,
		CDB_RESP = 2'b11
	} cdb_state_t;

	// Odd parity companion: the pair always holds an odd number of ones
	function automatic logic cdb_odd_par(input logic sig);
		return ~sig;
	endfunction

	// Checksum over the address phase: byte-wise xor of address, lanes and attributes; wdata is not folded in
	function automatic logic [ACHK_W-1:0] cdb_achk(
		input logic [ADDR_W-1:0]  addr,
		input logic [LANES-1:0]   lanes,
		input logic               we,
		input logic [MTYPE_W-1:0] mtype,
		input logic [PROT_W-1:0]  prot,
		input logic               dbg,
		input logic [DATA_W-1:0]  wdata);
		logic [ACHK_W-1:0] acc;
		acc = {{(ACHK_W-LANES){1'b0}}, lanes};
		for (int i = 0; i < ADDR_W / ACHK_W; i++)
		begin
			acc = acc ^ addr[i*ACHK_W +: ACHK_W];
		end
		acc = acc ^ {{(ACHK_W-PROT_W-MTYPE_W-2){1'b0}}, dbg, we, mtype, prot};
		return acc;
	endfunction
endpackage

// ==== logic/cdb_if.sv ====
`timescale 1ns/10ps
interface cdb_if;
	import cdb_pkg::*;
	logic                 req;
	logic                 req_par;
	logic                 gnt;
	logic                 gnt_par;
	logic [ADDR_W-1:0]    addr;
	logic [LANES-1:0]     mem_byte_lanes;
	logic                 we;
	logic [MTYPE_W-1:0]   mtype;
	logic [PROT_W-1:0]    prot;
	logic                 dbg;
	logic [DATA_W-1:0]    wdata;
	logic [ACHK_W-1:0]    achk;
	logic                 rvalid;
	logic [DATA_W-1:0]    rdata;
	logic                 err;

	modport core (output req, req_par, addr, mem_byte_lanes, we, mtype, prot, dbg, wdata,
		achk, input gnt, gnt_par, rvalid, rdata, err);
	modport sub (input req, req_par, addr, mem_byte_lanes, we, mtype, prot, dbg, wdata,
		achk, output gnt, gnt_par, rvalid, rdata, err);
endinterface

// ==== logic/cdb_sub.sv ====
`timescale 1ns/10ps
// Subordinate end: a flop-based memory that grants when not busy
module cdb_sub #(
	parameter int DEPTH = 16
) (
	input  wire logic                  i_mclk,
	input  wire logic                  i_rstn,
	cdb_if.sub                         bus,
	input  wire logic                  i_stall,
	input  wire logic                  i_inject_err,
	output logic                       o_achk_bad
);
	import cdb_pkg::*;
	localparam int IDX_W = $clog2(DEPTH);

	logic [DATA_W-1:0] mem_reg [DEPTH];
	logic              gnt_reg;
	logic              rvalid_reg;
	logic              err_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic              pend_reg;
	logic [IDX_W-1:0]  idx;
	logic              take;

	assign idx  = bus.addr[IDX_W+1:2];
	assign take = bus.req && !gnt_reg && !pend_reg && !i_stall;

	// ----------------------------------------------------------------
	// Grant, one cycle per request
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			gnt_reg <= 1'b0;
		else
			gnt_reg <= take;
	end
	assign bus.gnt     = gnt_reg;
	assign bus.gnt_par = cdb_odd_par(gnt_reg); // [RQ4]

	// Response one cycle after the grant, single cycle pulse
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pend_reg   <= 1'b0;
			rvalid_reg <= 1'b0;
			err_reg    <= 1'b0;
			rdata_reg  <= DATA_RST;
			o_achk_bad <= 1'b0;
		end
		else
		begin
			pend_reg   <= take;
			rvalid_reg <= gnt_reg; // [RQ12]
			err_reg    <= gnt_reg && i_inject_err; // [RQ14]
			if (take)
			begin
				rdata_reg  <= bus.we ? DATA_RST : mem_reg[idx]; // [RQ13]
				o_achk_bad <= bus.achk != cdb_achk(bus.addr, bus.mem_byte_lanes, bus.we,
					bus.mtype, bus.prot, bus.dbg, bus.wdata);
			end
		end
	end
	assign bus.rvalid = rvalid_reg;
	assign bus.err    = err_reg;
	assign bus.rdata  = rdata_reg;

	// Byte-lane writes into storage
	always_ff @(posedge i_mclk)
	begin
		if (take && bus.we)
			for (int b = 0; b < LANES; b++)
				if (bus.mem_byte_lanes[b])
					mem_reg[idx][b*8 +: 8] <= bus.wdata[b*8 +: 8];
	end
endmodule // cdb_sub

// ==== logic/cdb_core.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// RQ1 - Hold request until grant seen
// RQ2 - Request companion carries odd parity
// RQ3 - Attributes may change after grant cycle
// RQ4 - Grant companion carries odd parity
// RQ5 - Address presented with request
// RQ6 - Lane enable per accessed byte
// RQ7 - Protection presented with request
// RQ8 - Cacheable/bufferable type presented with request
// RQ9 - Debug-origin flag presented with request
// RQ10 - Write enable high write, low read
// RQ11 - Checksum over address phase outputs
// RQ12 - Response valid exactly one cycle
// RQ13 - Read data sampled only on response
// RQ14 - Error meaningful only with response
// RQ15 - Address phase stable until grant

// Core end of the data bus. One transfer is in flight at a time: each
// costs three cycles from command to done, traded for trivial pairing of
// responses. Errors are reported with done and never retried here; the
// command side decides what a failed transfer means.
module cdb_core (
	input  wire logic                           i_mclk,
	input  wire logic                           i_rstn,
	cdb_if.core                                 bus,
	input  wire logic                           i_cmd_valid,
	input  wire logic [cdb_pkg::ADDR_W-1:0]     i_cmd_addr,
	input  wire logic                           i_cmd_we,
	input  wire logic [cdb_pkg::LANES-1:0]      i_cmd_lanes,
	input  wire logic [cdb_pkg::DATA_W-1:0]     i_cmd_wdata,
	input  wire logic                           i_cmd_cache,
	input  wire logic                           i_cmd_buf,
	input  wire logic [cdb_pkg::PROT_W-1:0]     i_cmd_prot,
	input  wire logic                           i_cmd_dbg,
	output logic                                o_cmd_ready,
	output logic                                o_done,
	output logic                                o_done_err,
	output logic [cdb_pkg::DATA_W-1:0]          o_rdata
);
	import cdb_pkg::*;

	// ----------------------------------------------------------------
	// Registered address phase
	// ----------------------------------------------------------------
	cdb_state_t          state_reg;
	logic                req_reg;
	logic                req_par_reg;
	logic [ADDR_W-1:0]   addr_reg;
	logic [LANES-1:0]    lanes_reg;
	logic                we_reg;
	logic [MTYPE_W-1:0]  mtype_reg;
	logic [PROT_W-1:0]   prot_reg;
	logic                dbg_reg;
	logic [DATA_W-1:0]   wdata_reg;
	logic [ACHK_W-1:0]   achk_reg;
	logic                launch;
	logic                gnt_hit;
	logic                resp_hit;

	// ----------------------------------------------------------------
	// Event decode
	// ----------------------------------------------------------------
	// Only one transfer outstanding keeps response pairing trivial
	assign launch   = i_cmd_valid && o_cmd_ready;
	// Grant and response count only in the state that waits for them, so
	// a stray strobe from the far side can never advance the sequence
	assign gnt_hit  = (state_reg == CDB_REQ) && bus.gnt;
	assign resp_hit = (state_reg == CDB_RESP) && bus.rvalid;

	// ----------------------------------------------------------------
	// Transfer sequencing
	// ----------------------------------------------------------------
	// Ready drops on launch and comes back with the response, so a new
	// command is never taken while the bus still owes an answer
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_reg   <= CDB_IDLE;
			o_cmd_ready <= 1'b1;
		end
		else
		begin
			case (state_reg)
				CDB_IDLE:
					if (launch)
					begin
						state_reg   <= CDB_REQ;
						o_cmd_ready <= 1'b0;
					end
				CDB_REQ:
					if (gnt_hit)
					begin
						state_reg <= CDB_RESP; // [RQ1]
					end
				CDB_RESP:
					if (resp_hit)
					begin
						state_reg   <= CDB_IDLE;
						o_cmd_ready <= 1'b1;
					end
				default:
				begin
					// Unused code: fall back to idle and offer ready again
					state_reg   <= CDB_IDLE;
					o_cmd_ready <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Request handshake
	// ----------------------------------------------------------------
	// Request and its parity; dropped in the cycle after the grant. The
	// parity flop is loaded from the same event, so the pair never splits
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			req_reg     <= 1'b0;
			req_par_reg <= 1'b1;
		end
		else if (launch)
		begin
			req_reg     <= 1'b1; // [RQ1]
			req_par_reg <= cdb_odd_par(1'b1); // [RQ2]
		end
		else if (gnt_hit)
		begin
			req_reg     <= 1'b0;
			req_par_reg <= cdb_odd_par(1'b0); // [RQ2]
		end
	end

	// ----------------------------------------------------------------
	// Address phase
	// ----------------------------------------------------------------
	// Loads only on launch, so it stays put until grant and beyond; the
	// far side may therefore sample it on any cycle of the request
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			addr_reg  <= ADDR_RST;
			lanes_reg <= '0;
			we_reg    <= 1'b0;
			mtype_reg <= '0;
			prot_reg  <= '0;
			dbg_reg   <= 1'b0;
			wdata_reg <= DATA_RST;
			achk_reg  <= ACHK_RST;
		end
		else if (launch) // [RQ15] [RQ3]
		begin
			addr_reg                   <= i_cmd_addr; // [RQ5]
			lanes_reg                  <= i_cmd_lanes; // [RQ6]
			we_reg                     <= i_cmd_we; // [RQ10]
			mtype_reg[MTYPE_CACHE_BIT] <= i_cmd_cache; // [RQ8]
			mtype_reg[MTYPE_BUF_BIT]   <= i_cmd_buf; // [RQ8]
			prot_reg                   <= i_cmd_prot; // [RQ7]
			dbg_reg                    <= i_cmd_dbg; // [RQ9]
			wdata_reg                  <= i_cmd_we ? i_cmd_wdata : DATA_RST;
			achk_reg <= cdb_achk(i_cmd_addr, i_cmd_lanes, i_cmd_we,
				{i_cmd_cache, i_cmd_buf}, i_cmd_prot, i_cmd_dbg, i_cmd_wdata); // [RQ11]
		end
	end

	// ----------------------------------------------------------------
	// Bus drive
	// ----------------------------------------------------------------
	// Every bus output comes straight from a flop, so no glitch reaches
	// the far side's checksum logic
	assign bus.req            = req_reg;
	assign bus.req_par        = req_par_reg;
	assign bus.addr           = addr_reg;
	assign bus.mem_byte_lanes = lanes_reg;
	assign bus.we             = we_reg;
	assign bus.mtype          = mtype_reg;
	assign bus.prot           = prot_reg;
	assign bus.dbg            = dbg_reg;
	assign bus.wdata          = wdata_reg;
	assign bus.achk           = achk_reg;

	// ----------------------------------------------------------------
	// Response capture
	// ----------------------------------------------------------------
	// Data and error are looked at only while response valid is high
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_done     <= 1'b0;
			o_done_err <= 1'b0;
			o_rdata    <= DATA_RST;
		end
		else
		begin
			o_done     <= resp_hit;
			o_done_err <= resp_hit && bus.err; // [RQ14]
			// Read data holds until the next read, writes leave it alone
			if (resp_hit && !we_reg)
			begin
				o_rdata <= bus.rdata; // [RQ13]
			end
		end
	end
endmodule // cdb_core

// ==== test/cdb_checker.sv ====
`timescale 1ns/10ps
// ------------------------------------------------
// Protocol watch on the joined bus
// ------------------------------------------------
module cdb_checker (
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        req,
	input  wire logic        req_par,
	input  wire logic        gnt,
	input  wire logic        gnt_par,
	input  wire logic [31:0] addr,
	input  wire logic [3:0]  mem_byte_lanes,
	input  wire logic        we,
	input  wire logic [1:0]  mtype,
	input  wire logic [2:0]  prot,
	input  wire logic        dbg,
	input  wire logic [31:0] wdata,
	input  wire logic [7:0]  achk,
	input  wire logic        rvalid,
	input  wire logic        err
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	// Request waits for its grant, then leaves
	property p_req_hold; req && !gnt |=> req; endproperty
	a_req_hold: assert property (p_req_hold) else $error("req dropped early");
	property p_req_drop; gnt |=> !req; endproperty
	a_req_drop: assert property (p_req_drop) else $error("req held after gnt");
	// Companions are always the inverse, so a pair holds one 1
	property p_req_par; req_par == !req; endproperty
	a_req_par: assert property (p_req_par) else $error("req parity");
	property p_gnt_par; gnt_par == !gnt; endproperty
	a_gnt_par: assert property (p_gnt_par) else $error("gnt parity");
	// Address phase frozen while waiting
	property p_stable;
		req && !gnt |=> $stable({addr, mem_byte_lanes, we, mtype, prot, dbg, wdata, achk});
	endproperty
	a_stable: assert property (p_stable) else $error("addr phase moved");
	property p_resp; gnt |=> rvalid ##1 !rvalid; endproperty
	a_resp: assert property (p_resp) else $error("rvalid not one cycle");
	property p_err; err |-> rvalid; endproperty
	a_err: assert property (p_err) else $error("err without rvalid");
	// Checksum: address bytes, lanes and attributes folded by xor
	property p_achk;
		req |-> achk == (addr[7:0] ^ addr[15:8] ^ addr[23:16] ^ addr[31:24]
			^ {4'h0, mem_byte_lanes} ^ {1'b0, dbg, we, mtype, prot});
	endproperty
	a_achk: assert property (p_achk) else $error("checksum");
endmodule // cdb_checker

// ==== test/tb_core_data_bus_port.sv ====
`timescale 1ns/10ps
module tb_core_data_bus_port;
	import cdb_pkg::*;
	logic        i_mclk = 0;
	logic        i_rstn = 0;
	logic        v = 0, we = 0, ca = 0, bf = 0, dbg = 0, st = 0, ie = 0;
	logic [31:0] ad = 0, wd = 0;
	logic [3:0]  ln = 0;
	logic [2:0]  pr = 0;
	logic        rdy, done, derr, bad;
	logic [31:0] rd;
	int          err_count = 0, compares = 0;
	cdb_if bus_if ();
	cdb_core cdb_core_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .bus(bus_if.core),
		.i_cmd_valid(v), .i_cmd_addr(ad), .i_cmd_we(we), .i_cmd_lanes(ln), .i_cmd_wdata(wd),
		.i_cmd_cache(ca), .i_cmd_buf(bf), .i_cmd_prot(pr), .i_cmd_dbg(dbg), .o_cmd_ready(rdy),
		.o_done(done), .o_done_err(derr), .o_rdata(rd));
	cdb_sub cdb_sub_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .bus(bus_if.sub), .i_stall(st),
		.i_inject_err(ie), .o_achk_bad(bad));
	cdb_checker cdb_checker_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .req(bus_if.req),
		.req_par(bus_if.req_par), .gnt(bus_if.gnt), .gnt_par(bus_if.gnt_par),
		.addr(bus_if.addr), .mem_byte_lanes(bus_if.mem_byte_lanes), .we(bus_if.we),
		.mtype(bus_if.mtype), .prot(bus_if.prot), .dbg(bus_if.dbg),
		.wdata(bus_if.wdata), .achk(bus_if.achk),
		.rvalid(bus_if.rvalid), .err(bus_if.err));
	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One transfer; n cycles of withheld grant test the hold
	task automatic xfer(input logic [31:0] a, d, input logic w, input logic [3:0] l,
		input logic [2:0] p, input logic c, b, g, input int n);
		int k;
		logic [7:0] sum;
		ad = a;
		wd = d;
		we = w;
		ln = l;
		pr = p;
		ca = c;
		bf = b;
		dbg = g;
		st = (n > 0);
		v = 1;
		@(negedge i_mclk);
		v = 0;
		chk(bus_if.req_par, 0);
		chk(bus_if.addr, a);
		chk(bus_if.mem_byte_lanes, l);
		chk(bus_if.prot, p);
		chk(bus_if.mtype, {c, b});
		chk(bus_if.dbg, g);
		chk(bus_if.we, w);
		// Checksum folded here by hand, independent of the package function
		sum = a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ {4'h0, l} ^ {1'b0, g, w, c, b, p};
		chk(bus_if.achk, sum);
		if (w)
			chk(bus_if.wdata, d);
		chk(rdy, 0);
		repeat (n) @(negedge i_mclk);
		chk(bus_if.req, 1);
		chk(bus_if.gnt_par, 1);
		chk(bus_if.addr, a);
		st = 0;
		k = 0;
		// Bounded wait so a lost response cannot hang the run
		while (done !== 1'b1 && k < 20)
		begin
			@(negedge i_mclk);
			k++;
		end
		chk(done, 1);
		chk(derr, ie);
		chk(bad, 0);
		chk(rdy, 1);
		chk(bus_if.req, 0);
	endtask
	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_rw;
		xfer(32'h0000_0014, 32'h1122_3344, 1, 4'hf, 3'h5, 1, 0, 0, 0);
		xfer(32'h0000_0014, 32'haabb_ccdd, 1, 4'h2, 3'h2, 0, 1, 1, 0);
		xfer(32'h0000_0014, 32'h0, 0, 4'hf, 3'h0, 1, 1, 0, 0);
		chk(rd, 32'h1122_cc44);
	endtask
	task automatic t_stall;
		xfer(32'h0000_0020, 32'h0bad_f00d, 1, 4'hf, 3'h7, 0, 0, 1, 3);
		xfer(32'h0000_0020, 32'h0, 0, 4'hf, 3'h1, 0, 0, 0, 1);
		chk(rd, 32'h0bad_f00d);
	endtask
	task automatic t_err;
		ie = 1;
		xfer(32'h0000_0014, 32'h0, 0, 4'hf, 3'h0, 0, 0, 0, 0);
		ie = 0;
		xfer(32'h0000_0014, 32'h0, 0, 4'hf, 3'h0, 0, 0, 0, 0);
	endtask
	task automatic t_attr;
		for (int i = 0; i < 4; i++)
		begin
			xfer(i * 4, i, 1, 4'h1 << i, i[2:0], i[1], i[0], i[0], 0);
		end
	endtask
	// Mid-run reset while idle, then a read to show the link recovers
	task automatic t_reset;
		i_rstn = 0;
		@(negedge i_mclk);
		chk(rdy, 1);
		chk(bus_if.req, 0);
		chk(bus_if.req_par, 1);
		chk(bus_if.gnt_par, 1);
		chk(done, 0);
		chk(rd, 32'h0);
		i_rstn = 1;
		xfer(32'h0000_0020, 32'h0, 0, 4'hf, 3'h0, 0, 0, 0, 0);
		chk(rd, 32'h0bad_f00d);
	endtask
	task automatic close_out;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		forever #20 i_mclk = ~i_mclk;
	end
	initial
	begin
		repeat (5) @(negedge i_mclk);
		i_rstn = 1;
		t_rw();
		t_stall();
		t_err();
		t_attr();
		t_reset();
		close_out();
	end
	// Watchdog: 400 cycles, far beyond the few dozen cycles the tests need
	initial
	begin
		#(40 * 400);
		err_count++;
		close_out();
	end
endmodule // tb_core_data_bus_port
